// >>> rtl/cia_pkg.sv
package cia_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PIN_N = 8;
  // Register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] LINK_OFS = 8'h08;
  localparam logic [7:0] CMD_OFS = 8'h0c;
  // Control fields
  localparam int SEL_LSB = 0;
  localparam int LEN_LSB = 4;
  localparam int FSK_LAYER = 3;
  localparam int OVEN_BIT = 8;
  localparam int OVVAL_BIT = 9;
  localparam int INV_BIT = 10;
  localparam int QTX_BIT = 11;
  localparam int QRX_BIT = 12;
  localparam int PLLEN_BIT = 13;
  localparam int RAW_BIT = 16;
  localparam int EFF_BIT = 17;
  // Status fields
  localparam int SEEN_BIT = 0;
  localparam int TXAB_BIT = 1;
  localparam int RXAB_BIT = 2;
  // Link fields
  localparam int UNLK_BIT = 0;
  localparam int DONE_BIT = 1;
  localparam int ST_LSB = 4;
  // Command fields
  localparam int GOTX_BIT = 0;
  localparam int GORX_BIT = 1;
  localparam int STOP_BIT = 2;
  // Reset values
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [3:0] LEN_RST = 4'h0;
  // Warm-down timing
  localparam int CLK_NS = 40;
  localparam int WD_TIME_NS = 320;
  localparam int WD_CYC = (WD_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] WD_LOAD = 4'(WD_CYC);
  typedef enum logic [1:0] {
    LL_IDLE,
    LL_TX,
    LL_RX,
    LL_WD
  } cia_ll_state_t;
endpackage

// >>> rtl/cia_coex_inhibit_abort.sv
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module cia_coex_inhibit_abort
  import cia_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  input wire logic [PIN_N-1:0] inhibit_pins_in,
  input wire logic synth_unlock_in,
  output logic [3:0] layer_inhibit_out,
  output logic fsk_tx_en_out,
  output logic fsk_rx_en_out,
  output logic pll_abort_out
);

  ////////////////////////////////////////////////////////////
  // Register bank
  logic [2:0] pin_sel_reg;
  logic [3:0] layer_en_reg;
  logic ovrd_en_reg;
  logic ovrd_val_reg;
  logic inv_reg;
  logic qual_tx_reg;
  logic qual_rx_reg;
  logic pll_en_reg;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_link;
  logic wr_cmd;

  assign wr_ctrl = wr_in && (addr_in == CTRL_OFS);
  assign wr_stat = wr_in && (addr_in == STAT_OFS);
  assign wr_link = wr_in && (addr_in == LINK_OFS);
  assign wr_cmd = wr_in && (addr_in == CMD_OFS);

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      pin_sel_reg <= SEL_RST;
      layer_en_reg <= LEN_RST;
      ovrd_en_reg <= 1'b0;
      ovrd_val_reg <= 1'b0;
      inv_reg <= 1'b0;
      qual_tx_reg <= 1'b0;
      qual_rx_reg <= 1'b0;
      pll_en_reg <= 1'b0;
    end else if (wr_ctrl) begin
      pin_sel_reg <= wdata_in[SEL_LSB +: 3];
      layer_en_reg <= wdata_in[LEN_LSB +: 4];
      ovrd_en_reg <= wdata_in[OVEN_BIT];
      ovrd_val_reg <= wdata_in[OVVAL_BIT];
      inv_reg <= wdata_in[INV_BIT];
      qual_tx_reg <= wdata_in[QTX_BIT];
      qual_rx_reg <= wdata_in[QRX_BIT];
      pll_en_reg <= wdata_in[PLLEN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////
  // Inhibit input path
  logic pin_mux;
  logic sync1_reg;
  logic sync2_reg;
  logic inh_eff;
  logic inh_prev_reg;
  logic inh_rise;

  assign pin_mux = inhibit_pins_in[pin_sel_reg];

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_mux;
      sync2_reg <= sync1_reg;
    end
  end

  // Override wins over pin, invert acts on the pin only
  assign inh_eff = ovrd_en_reg ? ovrd_val_reg
                               : (sync2_reg ^ inv_reg);

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      inh_prev_reg <= 1'b0;
    end else begin
      inh_prev_reg <= inh_eff;
    end
  end

  assign inh_rise = inh_eff && !inh_prev_reg;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      layer_inhibit_out <= 4'h0;
    end else begin
      layer_inhibit_out <= layer_en_reg & {4{inh_eff}};
    end
  end

  ////////////////////////////////////////////////////////////
  // Abort decision in the sequence manager
  cia_ll_state_t state_reg;
  cia_ll_state_t state_next;
  logic fsk_on;
  logic tx_ab;
  logic rx_ab;
  logic unlk_ab;
  logic abort_req;
  logic pll_abort_reg;

  assign fsk_on = layer_en_reg[FSK_LAYER] && inh_rise;
  assign tx_ab = fsk_on && qual_tx_reg && (state_reg == LL_TX);
  assign rx_ab = fsk_on && qual_rx_reg && (state_reg == LL_RX);
  assign unlk_ab = pll_en_reg && synth_unlock_in &&
                   ((state_reg == LL_TX) || (state_reg == LL_RX));
  assign abort_req = tx_ab || rx_ab || unlk_ab;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      pll_abort_reg <= 1'b0;
    end else begin
      pll_abort_reg <= abort_req;
    end
  end

  assign pll_abort_out = pll_abort_reg;

  ////////////////////////////////////////////////////////////
  // Coexistence status flags, set wins over clear
  logic seen_reg;
  logic txab_reg;
  logic rxab_reg;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      seen_reg <= 1'b0;
      txab_reg <= 1'b0;
      rxab_reg <= 1'b0;
    end else begin
      if (inh_rise) begin
        seen_reg <= 1'b1;
      end else if (wr_stat && wdata_in[SEEN_BIT]) begin
        seen_reg <= 1'b0;
      end
      if (tx_ab) begin
        txab_reg <= 1'b1;
      end else if (wr_stat && wdata_in[TXAB_BIT]) begin
        txab_reg <= 1'b0;
      end
      if (rx_ab) begin
        rxab_reg <= 1'b1;
      end else if (wr_stat && wdata_in[RXAB_BIT]) begin
        rxab_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Warm-down timer of the sequence manager
  logic [3:0] wd_cnt_reg;
  logic seq_idle;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      wd_cnt_reg <= 4'h0;
    end else if (state_reg != LL_WD && state_next == LL_WD) begin
      wd_cnt_reg <= WD_LOAD;
    end else if (wd_cnt_reg != 4'h0) begin
      wd_cnt_reg <= wd_cnt_reg - 4'h1;
    end
  end

  assign seq_idle = (wd_cnt_reg == 4'h0);

  ////////////////////////////////////////////////////////////
  // FSK link layer sequencer
  logic go_tx;
  logic go_rx;
  logic go_stop;

  // Launch refused while inhibit stands
  assign go_tx = wr_cmd && wdata_in[GOTX_BIT] && !inh_eff;
  assign go_rx = wr_cmd && wdata_in[GORX_BIT] && !inh_eff;
  assign go_stop = wr_cmd && wdata_in[STOP_BIT];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LL_IDLE: begin
        if (go_tx) begin
          state_next = LL_TX;
        end else if (go_rx) begin
          state_next = LL_RX;
        end
      end
      LL_TX, LL_RX: begin
        if (pll_abort_reg || go_stop) begin
          state_next = LL_WD;
        end
      end
      LL_WD: begin
        if (seq_idle) begin
          state_next = LL_IDLE;
        end
      end
      default: begin
        state_next = LL_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      state_reg <= LL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      fsk_tx_en_out <= 1'b0;
      fsk_rx_en_out <= 1'b0;
    end else begin
      fsk_tx_en_out <= (state_next == LL_TX);
      fsk_rx_en_out <= (state_next == LL_RX);
    end
  end

  ////////////////////////////////////////////////////////////
  // Link layer interrupt flags
  logic unlk_irq_reg;
  logic done_irq_reg;
  logic done_set;

  assign done_set = (state_reg == LL_WD) && seq_idle;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      unlk_irq_reg <= 1'b0;
      done_irq_reg <= 1'b0;
    end else begin
      if (pll_abort_reg && (state_reg == LL_TX || state_reg == LL_RX)) begin
        unlk_irq_reg <= 1'b1;
      end else if (wr_link && wdata_in[UNLK_BIT]) begin
        unlk_irq_reg <= 1'b0;
      end
      if (done_set) begin
        done_irq_reg <= 1'b1;
      end else if (wr_link && wdata_in[DONE_BIT]) begin
        done_irq_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Read port
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (addr_in)
      CTRL_OFS: begin
        rd_mux[SEL_LSB +: 3] = pin_sel_reg;
        rd_mux[LEN_LSB +: 4] = layer_en_reg;
        rd_mux[OVEN_BIT] = ovrd_en_reg;
        rd_mux[OVVAL_BIT] = ovrd_val_reg;
        rd_mux[INV_BIT] = inv_reg;
        rd_mux[QTX_BIT] = qual_tx_reg;
        rd_mux[QRX_BIT] = qual_rx_reg;
        rd_mux[PLLEN_BIT] = pll_en_reg;
        rd_mux[RAW_BIT] = sync2_reg;
        rd_mux[EFF_BIT] = inh_eff;
      end
      STAT_OFS: begin
        rd_mux[SEEN_BIT] = seen_reg;
        rd_mux[TXAB_BIT] = txab_reg;
        rd_mux[RXAB_BIT] = rxab_reg;
      end
      LINK_OFS: begin
        rd_mux[UNLK_BIT] = unlk_irq_reg;
        rd_mux[DONE_BIT] = done_irq_reg;
        rd_mux[ST_LSB +: 2] = state_reg;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      rdata_out <= rd_mux;
    end else begin
      rdata_out <= '0;
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  AST_SEEN_SET: assert property (
    inh_rise |=> seen_reg)
    else $error("seen flag not set");

  AST_SEEN_STICKY: assert property (
    seen_reg && !(wr_stat && wdata_in[SEEN_BIT]) |=> seen_reg)
    else $error("seen flag lost");

  AST_TX_ABORT: assert property (
    inh_rise && layer_en_reg[FSK_LAYER] && qual_tx_reg &&
    state_reg == LL_TX |=> txab_reg && pll_abort_reg
    ##1 state_reg == LL_WD && unlk_irq_reg)
    else $error("tx abort missing");

  AST_RX_ABORT: assert property (
    inh_rise && layer_en_reg[FSK_LAYER] && qual_rx_reg &&
    state_reg == LL_RX |=> rxab_reg && pll_abort_reg
    ##1 !fsk_rx_en_out)
    else $error("rx abort missing");

  AST_FSK_IGNORE: assert property (
    !layer_en_reg[FSK_LAYER] && !synth_unlock_in |=> !pll_abort_reg)
    else $error("abort while layer off");

  AST_WD_DROP: assert property (
    state_reg == LL_WD |-> !fsk_tx_en_out && !fsk_rx_en_out)
    else $error("request held in warm-down");

  AST_WD_END: assert property (
    $rose(state_reg == LL_WD) |-> (state_reg == LL_WD) [*8]
    ##1 state_reg == LL_WD ##1 state_reg == LL_IDLE && done_irq_reg)
    else $error("warm-down length wrong");

  AST_NO_LAUNCH: assert property (
    inh_eff && state_reg == LL_IDLE |=> state_reg == LL_IDLE)
    else $error("launch under inhibit");

  AST_OVRD: assert property (
    ovrd_en_reg && ovrd_val_reg |=> layer_inhibit_out == $past(layer_en_reg))
    else $error("override not applied");

endmodule // cia_coex_inhibit_abort
`default_nettype wire

// >>> testbench/cia_wlan_model.sv
`timescale 1ns/10ps
`default_nettype none
// Far-side chip: drives the inhibit level on one selected pin
module cia_wlan_model (
  input wire logic [2:0] sel_in,
  input wire logic level_in,
  output logic [7:0] pins_out
);
  always_comb begin
    pins_out = 8'h00;
    pins_out[sel_in] = level_in;
  end
endmodule // cia_wlan_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import cia_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [PIN_N-1:0] pins;
  logic unlock = 1'b0;
  logic [3:0] layer;
  logic tx_en;
  logic rx_en;
  logic pll;
  logic level = 1'b0;
  int n_fail = 0;
  int num_checks = 0;
  logic [31:0] d;

  always #20 core_clk_in = ~core_clk_in;

  cia_wlan_model WLAN (.sel_in(3'h2), .level_in(level), .pins_out(pins));

  cia_coex_inhibit_abort DUT (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .inhibit_pins_in(pins), .synth_unlock_in(unlock),
    .layer_inhibit_out(layer), .fsk_tx_en_out(tx_en),
    .fsk_rx_en_out(rx_en), .pll_abort_out(pll)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Checks %0d, errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic bw(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
  endtask

  task automatic br(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic wait_pll();
    int i;
    #1;
    for (i = 0; i < 8 && pll !== 1'b1; i++) begin
      @(posedge core_clk_in);
      #1;
    end
    chk({31'h0, pll}, 32'h1);
    @(posedge core_clk_in);
    #1;
    chk({31'h0, pll}, 32'h0);
  endtask

  task automatic clr_all();
    bw(STAT_OFS, 32'h7);
    bw(LINK_OFS, 32'h3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    br(CTRL_OFS, d);
    chk(d, 32'h0);
    br(STAT_OFS, d);
    chk(d, 32'h0);
    br(LINK_OFS, d);
    chk(d, 32'h0);
    br(8'h10, d);
    chk(d, 32'h0);
  endtask

  task automatic t_tx_abort();
    bw(CTRL_OFS, 32'h882);
    bw(CMD_OFS, 32'h1);
    #1;
    chk({31'h0, tx_en}, 32'h1);
    @(posedge core_clk_in);
    level <= 1'b1;
    wait_pll();
    repeat (2) @(posedge core_clk_in);
    #1;
    chk({31'h0, tx_en}, 32'h0);
    br(STAT_OFS, d);
    chk(d, 32'h3);
    br(LINK_OFS, d);
    chk(d, 32'h31);
    repeat (12) @(posedge core_clk_in);
    br(LINK_OFS, d);
    chk(d, 32'h3);
    br(STAT_OFS, d);
    chk(d, 32'h3);
    br(CTRL_OFS, d);
    chk(d, 32'h30882);
    clr_all();
    br(STAT_OFS, d);
    chk(d, 32'h0);
  endtask

  task automatic t_refuse();
    bw(CMD_OFS, 32'h1);
    repeat (2) @(posedge core_clk_in);
    #1;
    chk({31'h0, tx_en}, 32'h0);
    @(posedge core_clk_in);
    level <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    bw(CMD_OFS, 32'h1);
    #1;
    chk({31'h0, tx_en}, 32'h1);
    bw(CMD_OFS, 32'h4);
    repeat (12) @(posedge core_clk_in);
    br(LINK_OFS, d);
    chk(d, 32'h2);
    clr_all();
  endtask

  task automatic t_rx_noqual();
    bw(CTRL_OFS, 32'h180);
    bw(CMD_OFS, 32'h2);
    bw(CTRL_OFS, 32'h380);
    repeat (4) @(posedge core_clk_in);
    #1;
    chk({31'h0, rx_en}, 32'h1);
    chk({28'h0, layer}, 32'h8);
    br(STAT_OFS, d);
    chk(d, 32'h1);
    bw(CTRL_OFS, 32'h1180);
    bw(CTRL_OFS, 32'h1380);
    wait_pll();
    repeat (14) @(posedge core_clk_in);
    br(STAT_OFS, d);
    chk(d, 32'h5);
    clr_all();
  endtask

  task automatic t_invert();
    bw(CTRL_OFS, 32'h482);
    repeat (4) @(posedge core_clk_in);
    #1;
    chk({28'h0, layer}, 32'h8);
    br(CTRL_OFS, d);
    chk(d, 32'h20482);
    bw(CTRL_OFS, 32'h0);
    clr_all();
  endtask

  task automatic t_unlock();
    bw(CTRL_OFS, 32'h2000);
    bw(CMD_OFS, 32'h2);
    @(posedge core_clk_in);
    unlock <= 1'b1;
    @(posedge core_clk_in);
    unlock <= 1'b0;
    wait_pll();
    repeat (14) @(posedge core_clk_in);
    br(STAT_OFS, d);
    chk(d, 32'h0);
    br(LINK_OFS, d);
    chk(d, 32'h3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_tx_abort();
    t_refuse();
    t_rx_noqual();
    t_invert();
    t_unlock();
    stop_test();
  end

  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
